// ---- hw/drive_cmd_pkg.sv ----
// Package: constants for the extended drive command word
package drive_cmd_pkg;
  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int BIT_FACTORY = 0;
  localparam int BIT_SAVE = 1;
  localparam int BIT_RESTORE = 2;
  localparam int BIT_UNIT = 9;
  localparam int BIT_FAST_STOP = 10;
  localparam int BIT_CHECK_OFF = 15;
  // Bits 3..8 carry no function and read back as zero
  localparam logic [15:0] RESERVED_MASK = 16'h01F8;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // Frequency scaling
  // ----------------------------------------------------------------
  localparam int FREQ_W = 16;
  // Default max frequency, in 0.1 Hz steps (60 Hz)
  localparam logic [15:0] MAX_FREQ_RESET = 16'h0258;
  localparam logic [15:0] HSP_RESET = 16'h01F4;
  localparam logic [31:0] FULL_SCALE = 32'h0000_7FFF;
  // ----------------------------------------------------------------
  // Parameter write select
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_MAX_FREQ = 2'h0;
  localparam logic [1:0] SEL_HIGH_SPEED = 2'h1;
  localparam logic [1:0] SEL_FREQ_SET = 2'h2;
  localparam logic [1:0] SEL_SPEED_SET = 2'h3;
  typedef enum logic [1:0] {CFG_IDLE, CFG_BUSY} cfg_state_t;
  typedef enum logic [1:0] {OP_NONE, OP_FACTORY, OP_SAVE, OP_RESTORE} cfg_op_t;
endpackage

// ---- hw/drive_extended_control_word.sv ----
// Extended drive command word with configuration handling and scaling
`timescale 1ns/1ps
// What this block does
// [R1] With the unit bit 9 at 0, frequency setpoint and output frequency are in 0.1 Hz steps.
// [R2] With the unit bit 9 at 1, they are signed 16-bit values scaled to the max frequency.
// [R3] The unit bit never changes the speed setpoint or output speed scaling.
// [R4] Fast stop is commanded while bit 10 is held at 1.
// [R5] The controller writes 0 to bits 3 to 8, which have no function.
// [R6] A bit 0 request loads factory defaults into working configuration.
// [R7] A bit 1 request copies working configuration into nonvolatile storage.
// [R8] Configuration commands act only on a 0-to-1 edge of their bit.
// [R9] A bit 2 request reloads working configuration from nonvolatile storage.
// [R10] Configuration commands are accepted only while the drive is stopped.
// [R11] With checking on, max frequency and high speed writes are checked against the configuration.
// [R12] With checking on, a high speed write above max frequency is clamped to it.
// [R13] With check bit at 1, checking is off and the drive is locked in stop.
// [R14] A 1-to-0 change of the check bit triggers recomputation of dependent values.
// [R15] After a save or restore completes, its request bit clears itself.
module drive_extended_control_word (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Command word access
  input wire logic cmd_wr_i,
  input wire logic [drive_cmd_pkg::WORD_W-1:0] cmd_wdata_i,
  output logic [drive_cmd_pkg::WORD_W-1:0] cmd_rdata_o,
  // Parameter writes
  input wire logic par_wr_i,
  input wire logic [1:0] par_sel_i,
  input wire logic [drive_cmd_pkg::FREQ_W-1:0] par_wdata_i,
  // Drive status and storage engine
  input wire logic drive_stopped_i,
  output logic cfg_req_o,
  output logic [1:0] cfg_op_o,
  input wire logic cfg_done_i,
  // Drive controls
  output logic fast_stop_o,
  output logic run_lock_o,
  output logic recalc_o,
  // Frequencies and speeds
  input wire logic [drive_cmd_pkg::FREQ_W-1:0] motor_freq_i,
  input wire logic [drive_cmd_pkg::FREQ_W-1:0] motor_speed_i,
  output logic [drive_cmd_pkg::FREQ_W-1:0] output_frequency_o,
  output logic [drive_cmd_pkg::FREQ_W-1:0] output_speed_o,
  output logic [drive_cmd_pkg::FREQ_W-1:0] freq_ref_o,
  output logic [drive_cmd_pkg::FREQ_W-1:0] speed_ref_o,
  output logic [drive_cmd_pkg::FREQ_W-1:0] max_frequency_o,
  output logic [drive_cmd_pkg::FREQ_W-1:0] high_speed_limit_o
);
  import drive_cmd_pkg::*;

  // ----------------------------------------------------------------
  // Command word register
  // ----------------------------------------------------------------
  logic [15:0] cmd_q, cmd_d;
  logic [15:0] wr_val;
  logic [2:0] rise;
  logic check_fall;
  cfg_state_t st_q, st_d;
  cfg_op_t op_q, op_d;
  logic recalc_q, recalc_d;

  // Reserved bits forced to zero regardless of what is written
  assign wr_val = cmd_wdata_i & ~RESERVED_MASK; // R5
  // Edges seen only against the stored word, so a held level never re-triggers
  assign rise = cmd_wr_i ? (wr_val[2:0] & ~cmd_q[2:0]) : 3'h0; // R8
  assign check_fall = cmd_wr_i & cmd_q[BIT_CHECK_OFF] & ~wr_val[BIT_CHECK_OFF]; // R14

  always_comb begin
    cmd_d = cmd_q;
    st_d = st_q;
    op_d = op_q;
    recalc_d = check_fall;
    if (cmd_wr_i) begin
      cmd_d = wr_val;
    end
    case (st_q)
      CFG_IDLE: begin
        // Requests while running are dropped, not queued
        if (drive_stopped_i) begin // R10
          if (rise[BIT_FACTORY]) begin // R6
            st_d = CFG_BUSY;
            op_d = OP_FACTORY;
          end else if (rise[BIT_SAVE]) begin // R7
            st_d = CFG_BUSY;
            op_d = OP_SAVE;
          end else if (rise[BIT_RESTORE]) begin // R9
            st_d = CFG_BUSY;
            op_d = OP_RESTORE;
          end
        end
      end
      CFG_BUSY: begin
        if (cfg_done_i) begin
          st_d = CFG_IDLE;
          op_d = OP_NONE;
          // Save and restore bits self-clear; factory bit is left to software
          if (op_q == OP_SAVE) begin
            cmd_d[BIT_SAVE] = 1'b0; // R15
          end
          if (op_q == OP_RESTORE) begin
            cmd_d[BIT_RESTORE] = 1'b0; // R15
          end
        end
      end
      default: begin
        st_d = CFG_IDLE;
        op_d = OP_NONE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_q <= CMD_RESET;
      st_q <= CFG_IDLE;
      op_q <= OP_NONE;
      recalc_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      st_q <= st_d;
      op_q <= op_d;
      recalc_q <= recalc_d;
    end
  end

  assign cmd_rdata_o = cmd_q;
  assign cfg_req_o = (st_q == CFG_BUSY);
  assign cfg_op_o = op_q;
  assign fast_stop_o = cmd_q[BIT_FAST_STOP]; // R4
  assign run_lock_o = cmd_q[BIT_CHECK_OFF]; // R13
  assign recalc_o = recalc_q; // R14

  // ----------------------------------------------------------------
  // Parameters with consistency check
  // ----------------------------------------------------------------
  logic [15:0] maxf_q, maxf_d, hsp_q, hsp_d, fset_q, fset_d, sset_q, sset_d;
  logic check_on;

  assign check_on = ~cmd_q[BIT_CHECK_OFF]; // R13

  always_comb begin
    maxf_d = maxf_q;
    hsp_d = hsp_q;
    fset_d = fset_q;
    sset_d = sset_q;
    if (op_q == OP_FACTORY && cfg_done_i) begin
      maxf_d = MAX_FREQ_RESET;
      hsp_d = HSP_RESET;
    end else if (par_wr_i) begin
      if (par_sel_i == SEL_MAX_FREQ) begin
        maxf_d = par_wdata_i;
        // Keep the limit consistent with a lowered maximum
        if (check_on && hsp_q > par_wdata_i) begin // R11
          hsp_d = par_wdata_i;
        end
      end else if (par_sel_i == SEL_HIGH_SPEED) begin
        // Write accepted but limited
        hsp_d = (check_on && par_wdata_i > maxf_q) ? maxf_q : par_wdata_i; // R12
      end else if (par_sel_i == SEL_FREQ_SET) begin
        fset_d = par_wdata_i;
      end else begin
        sset_d = par_wdata_i; // R3
      end
    end
    // Recompute dependent values once checking is back on
    if (recalc_q && hsp_d > maxf_d) begin // R14
      hsp_d = maxf_d;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      maxf_q <= MAX_FREQ_RESET;
      hsp_q <= HSP_RESET;
      fset_q <= 16'h0000;
      sset_q <= 16'h0000;
    end else begin
      maxf_q <= maxf_d;
      hsp_q <= hsp_d;
      fset_q <= fset_d;
      sset_q <= sset_d;
    end
  end

  // ----------------------------------------------------------------
  // Unit scaling
  // ----------------------------------------------------------------
  // Standardized form: 0.1 Hz value * 32767 / max, signed; divider is costly
  // and is combinational, recomputing whenever fset_q, maxf_q or motor_freq_i changes
  logic [15:0] fref_d, fout_d, fref_q, fout_q;
  logic [31:0] prod_in, prod_out, tmp_in, tmp_out, maxf_safe;
  logic [15:0] mag_in, mag_out;

  always_comb begin
    maxf_safe = (maxf_q == 16'h0000) ? 32'h0000_0001 : {16'h0000, maxf_q};
    mag_in = fset_q[15] ? 16'(-fset_q) : fset_q;
    mag_out = motor_freq_i[15] ? 16'(-motor_freq_i) : motor_freq_i;
    // Setpoint arrives standardized: convert to internal 0.1 Hz
    prod_in = {16'h0000, mag_in} * {16'h0000, maxf_q};
    tmp_in = prod_in / FULL_SCALE;
    // Output leaves standardized
    prod_out = {16'h0000, mag_out} * FULL_SCALE;
    tmp_out = prod_out / maxf_safe;
    if (tmp_out > FULL_SCALE) begin
      tmp_out = FULL_SCALE;
    end
    if (cmd_q[BIT_UNIT]) begin // R2
      fref_d = fset_q[15] ? 16'(-tmp_in[15:0]) : tmp_in[15:0];
      fout_d = motor_freq_i[15] ? 16'(-tmp_out[15:0]) : tmp_out[15:0];
    end else begin // R1
      fref_d = fset_q;
      fout_d = motor_freq_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fref_q <= 16'h0000;
      fout_q <= 16'h0000;
    end else begin
      fref_q <= fref_d;
      fout_q <= fout_d;
    end
  end

  assign freq_ref_o = fref_q;
  assign output_frequency_o = fout_q;
  assign speed_ref_o = sset_q; // R3
  assign output_speed_o = motor_speed_i; // R3
  assign max_frequency_o = maxf_q;
  assign high_speed_limit_o = hsp_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R5
    (cmd_q & RESERVED_MASK) == 16'h0000) else $error("reserved bits set");
  a_fast_stop: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R4
    cmd_wr_i |=> fast_stop_o == $past(cmd_wdata_i[BIT_FAST_STOP]))
    else $error("fast stop mismatch");
  a_run_refused: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R10
    (st_q == CFG_IDLE && !drive_stopped_i) |=> st_q == CFG_IDLE)
    else $error("request taken while running");
  a_edge_start: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R8
    (st_q == CFG_IDLE && drive_stopped_i && rise[BIT_SAVE] && !rise[BIT_FACTORY])
    |=> (cfg_req_o && cfg_op_o == OP_SAVE)) else $error("save not started");
  a_held_level: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R8
    (st_q == CFG_IDLE && !cmd_wr_i) |=> st_q == CFG_IDLE)
    else $error("held level started a command");
  a_self_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R15
    (cfg_req_o && op_q == OP_SAVE && cfg_done_i && !cmd_wr_i) |=> !cmd_q[BIT_SAVE])
    else $error("save bit not cleared");
  a_clamp_hsp: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R12
    (par_wr_i && par_sel_i == SEL_HIGH_SPEED && check_on && par_wdata_i > maxf_q
     && !(op_q == OP_FACTORY && cfg_done_i)) |=> hsp_q == $past(maxf_q))
    else $error("high speed not clamped");
  a_recalc_pulse: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R14
    check_fall |=> (recalc_o ##1 !recalc_o || check_fall))
    else $error("recalc pulse wrong");
  a_unit_plain: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R1
    !cmd_q[BIT_UNIT] |=> fref_q == $past(fset_q)) else $error("0.1 Hz path wrong");
  a_speed_keep: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R3
    (cmd_q[BIT_UNIT] && par_wr_i && par_sel_i == SEL_SPEED_SET)
    |=> speed_ref_o == $past(par_wdata_i)) else $error("speed scaled");
  a_lock: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R13
    cmd_wr_i |=> run_lock_o == $past(cmd_wdata_i[BIT_CHECK_OFF]))
    else $error("lock mismatch");
  a_factory_first: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R6
    (st_q == CFG_IDLE && drive_stopped_i && rise[BIT_FACTORY])
    |=> (cfg_req_o && cfg_op_o == OP_FACTORY)) else $error("factory not started");
  a_factory_load: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R6
    (cfg_req_o && op_q == OP_FACTORY && cfg_done_i)
    |=> (maxf_q == MAX_FREQ_RESET && hsp_q == HSP_RESET)) else $error("defaults not loaded");
  a_restore_start: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R9
    (st_q == CFG_IDLE && drive_stopped_i && rise == 3'h4)
    |=> (cfg_req_o && cfg_op_o == OP_RESTORE)) else $error("restore not started");
  a_restore_clear: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R15
    (cfg_req_o && op_q == OP_RESTORE && cfg_done_i && !cmd_wr_i) |=> !cmd_q[BIT_RESTORE])
    else $error("restore bit not cleared");
  a_max_lower: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R11
    (par_wr_i && par_sel_i == SEL_MAX_FREQ && check_on && hsp_q > par_wdata_i
     && !(op_q == OP_FACTORY && cfg_done_i)) |=> hsp_q == $past(par_wdata_i))
    else $error("limit above lowered max");
  a_recalc_clamp: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R14
    recalc_o |=> hsp_q <= maxf_q)
    else $error("limit not recomputed");
  a_unit_scaled: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // R2
    (cmd_q[BIT_UNIT] && motor_freq_i == maxf_q && !maxf_q[15] && maxf_q != 16'h0000)
    |=> output_frequency_o == FULL_SCALE[15:0]) else $error("full scale wrong");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------

  c_save: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    cfg_req_o && op_q == OP_SAVE && cfg_done_i);
  c_restore: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    cfg_req_o && op_q == OP_RESTORE && cfg_done_i);
  c_clamp: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    par_wr_i && par_sel_i == SEL_HIGH_SPEED && check_on && par_wdata_i > maxf_q);
  c_recalc: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) recalc_o);
  c_factory: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
    cfg_req_o && op_q == OP_FACTORY && cfg_done_i);
endmodule

// ---- verif/cfg_engine_model.sv ----
// Storage engine model answering configuration requests
`timescale 1ns/1ps
module cfg_engine_model (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Request and answer
  input wire logic [3:0] delay_i,
  input wire logic cfg_req_i,
  output logic cfg_done_o
);
  int cnt;
  // Done is one pulse; the request only drops on the edge after it
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt <= 0;
      cfg_done_o <= 1'b0;
    end else begin
      cfg_done_o <= 1'b0;
      if (cfg_req_i && !cfg_done_o) begin
        if (cnt >= int'(delay_i)) begin
          cfg_done_o <= 1'b1;
          cnt <= 0;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule

// ---- verif/drive_extended_control_word_tb.sv ----
// Testbench for the extended drive command word
`timescale 1ns/1ps
module drive_extended_control_word_tb;
  import drive_cmd_pkg::*;
  logic sys_clk_i = 0, resetn_i = 0, cmd_wr_i = 0, par_wr_i = 0, drive_stopped_i = 1;
  logic [15:0] cmd_wdata_i = '0, par_wdata_i = '0, motor_freq_i = '0, motor_speed_i = '0;
  logic [15:0] cmd_rdata_o, output_frequency_o, output_speed_o, freq_ref_o, speed_ref_o;
  logic [15:0] max_frequency_o, high_speed_limit_o;
  logic [1:0] par_sel_i = '0, cfg_op_o;
  logic cfg_req_o, cfg_done_i, fast_stop_o, run_lock_o, recalc_o;
  logic [3:0] delay = 4'h0;
  int n_errors = 0, tests_run = 0, cycles = 0, hits, n_recalc = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  // Recalc pulses counted as they happen, whatever the sequence is doing
  always @(negedge sys_clk_i) n_recalc += int'(recalc_o === 1'b1);

  drive_extended_control_word dut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cmd_wr_i(cmd_wr_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o), .par_wr_i(par_wr_i),
    .par_sel_i(par_sel_i), .par_wdata_i(par_wdata_i), .drive_stopped_i(drive_stopped_i),
    .cfg_req_o(cfg_req_o), .cfg_op_o(cfg_op_o), .cfg_done_i(cfg_done_i),
    .fast_stop_o(fast_stop_o), .run_lock_o(run_lock_o), .recalc_o(recalc_o),
    .motor_freq_i(motor_freq_i), .motor_speed_i(motor_speed_i),
    .output_frequency_o(output_frequency_o), .output_speed_o(output_speed_o),
    .freq_ref_o(freq_ref_o), .speed_ref_o(speed_ref_o),
    .max_frequency_o(max_frequency_o), .high_speed_limit_o(high_speed_limit_o)
  );

  cfg_engine_model engine (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .delay_i(delay),
    .cfg_req_i(cfg_req_o), .cfg_done_o(cfg_done_i)
  );

  // ----------------------------------------------------------------
  // Access and checking tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_cmd(input logic [15:0] d);
    cmd_wr_i = 1'b1;
    cmd_wdata_i = d;
    @(negedge sys_clk_i);
    cmd_wr_i = 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic wr_par(input logic [1:0] s, input logic [15:0] d);
    par_wr_i = 1'b1;
    par_sel_i = s;
    par_wdata_i = d;
    @(negedge sys_clk_i);
    par_wr_i = 1'b0;
    @(negedge sys_clk_i);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 50 && cfg_req_o !== 1'b0; i++) @(negedge sys_clk_i);
    check("cfg_req_o", cfg_req_o, 16'h0000);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run needs under a hundred cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    @(negedge sys_clk_i);
    check("cmd_rdata_o", cmd_rdata_o, CMD_RESET);
    check("max_frequency_o", max_frequency_o, MAX_FREQ_RESET);
    check("high_speed_limit_o", high_speed_limit_o, HSP_RESET);
    // Slow engine, reserved bits written high
    delay = 4'h5;
    wr_cmd(16'h01FA);
    check("cmd_rdata_o", cmd_rdata_o, 16'h0002);
    check("cfg_op_o", cfg_op_o, OP_SAVE);
    check("cfg_req_o", cfg_req_o, 16'h0001);
    wait_idle();
    check("cmd_rdata_o", cmd_rdata_o, 16'h0000);
    delay = 4'h0;
    wr_cmd(16'h0004);
    check("cfg_op_o", cfg_op_o, OP_RESTORE);
    wait_idle();
    check("cmd_rdata_o", cmd_rdata_o, 16'h0000);
    wr_par(SEL_HIGH_SPEED, 16'h0100);
    check("high_speed_limit_o", high_speed_limit_o, 16'h0100);
    wr_cmd(16'h0001);
    check("cfg_op_o", cfg_op_o, OP_FACTORY);
    wait_idle();
    check("high_speed_limit_o", high_speed_limit_o, HSP_RESET);
    // Level held high and a request while running are both ignored
    wr_cmd(16'h0001);
    check("cfg_req_o", cfg_req_o, 16'h0000);
    drive_stopped_i = 1'b0;
    wr_cmd(16'h0003);
    check("cfg_req_o", cfg_req_o, 16'h0000);
    drive_stopped_i = 1'b1;
    wr_cmd(16'h0400);
    check("fast_stop_o", fast_stop_o, 16'h0001);
    wr_cmd(16'h0000);
    check("fast_stop_o", fast_stop_o, 16'h0000);
    wr_par(SEL_HIGH_SPEED, 16'h0300);
    check("high_speed_limit_o", high_speed_limit_o, MAX_FREQ_RESET);
    wr_cmd(16'h8000);
    check("run_lock_o", run_lock_o, 16'h0001);
    wr_par(SEL_HIGH_SPEED, 16'h0300);
    check("high_speed_limit_o", high_speed_limit_o, 16'h0300);
    hits = n_recalc;
    wr_cmd(16'h0000);
    repeat (2) @(negedge sys_clk_i);
    check("recalc_o pulses", 16'(n_recalc - hits), 16'h0001);
    check("high_speed_limit_o", high_speed_limit_o, MAX_FREQ_RESET);
    // Unit select: tenths of hertz, then standardized
    motor_freq_i = 16'h0100;
    motor_speed_i = 16'h1234;
    wr_par(SEL_FREQ_SET, 16'h0123);
    check("output_frequency_o", output_frequency_o, 16'h0100);
    check("freq_ref_o", freq_ref_o, 16'h0123);
    check("output_speed_o", output_speed_o, 16'h1234);
    wr_cmd(16'h0200);
    motor_freq_i = MAX_FREQ_RESET;
    wr_par(SEL_FREQ_SET, 16'h7FFF);
    check("output_frequency_o", output_frequency_o, 16'h7FFF);
    check("freq_ref_o", freq_ref_o, MAX_FREQ_RESET);
    check("output_speed_o", output_speed_o, 16'h1234);
    wr_par(SEL_SPEED_SET, 16'h0456);
    check("speed_ref_o", speed_ref_o, 16'h0456);
    // Lowering the maximum pulls the limit down with it
    motor_freq_i = 16'hFE00;
    wr_par(SEL_MAX_FREQ, 16'h0200);
    check("max_frequency_o", max_frequency_o, 16'h0200);
    check("high_speed_limit_o", high_speed_limit_o, 16'h0200);
    check("output_frequency_o", output_frequency_o, 16'h8001);
    check("freq_ref_o", freq_ref_o, 16'h0200);
    close_out();
  end
endmodule
